// ### dma_transfer_hierarchy_defines.vh
`ifndef DMA_TRANSFER_HIERARCHY_DEFINES_VH
`define DMA_TRANSFER_HIERARCHY_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_SRC       8'h04
`define OFS_DST       8'h08
`define OFS_UBLEN     8'h0C
`define OFS_BLEN      8'h10
`define OFS_STEP      8'h14
`define OFS_SOFF      8'h18
`define OFS_DOFF      8'h1C
`define OFS_NEXT      8'h20
`define OFS_STATUS    8'h24

// ----------------------------------------
// channel_config_reg fields
// ----------------------------------------
`define CC_START      0
`define CC_SYNC       1
`define CC_PERIPHERAL_REQUEST_ID_LO   2
`define CC_PERIPHERAL_REQUEST_ID_HI   7
`define CC_BURST_LO   8
`define CC_BURST_HI   10
`define CC_CHUNK_LO   11
`define CC_CHUNK_HI   13
`define CC_SFIX       14
`define CC_DFIX       15
`define CC_SOFF_EN    16
`define CC_DOFF_EN    17
`define CC_IRQ_BLK    18
`define CC_IRQ_EOL    19
`define CC_WIDTH      20

// ----------------------------------------
// descriptor layout and update mask
// ----------------------------------------
`define DESC_WORDS    3'h7
`define DM_SRC        0
`define DM_DST        1
`define DM_UBLEN      2
`define DM_BLEN       3
`define DM_STEP       4
`define DM_CTRL       5

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define RST_WORD      32'h0000_0000
`define RST_CTRL      20'h0_0000
`define MAX_GROUP     5'h10
`define BUF_DEPTH     16

// ----------------------------------------
// example request line numbers
// ----------------------------------------
`define REQ_AUDIO_A_RX_LEFT   6'h2D
`define REQ_AUDIO_B_RX_RIGHT  6'h33

`endif

// ### dma_request_select.v
`timescale 1ns/1ps
`include "dma_transfer_hierarchy_defines.vh"

module dma_request_select
(
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// request lines and selection
	input  wire [63:0] req_lines,
	input  wire [5:0]  peripheral_request_id,
	// selected request
	output reg         req_sel
);

wire [63:0] hit;

// ----------------------------------------
// one-hot decode of the line number
// ----------------------------------------
genvar g;
generate
	for (g = 0; g < 64; g = g + 1)
	begin : g_line
		localparam [31:0] LINE = g;
		assign hit[g] = req_lines[g] & ({26'h0000000, peripheral_request_id} == LINE);
	end
endgenerate

always @(posedge aclk)
begin
	if (!aresetn)
		req_sel <= 1'b0;
	else
		req_sel <= |hit;
end

endmodule // dma_request_select

// ### dma_axil_regs.v
`timescale 1ns/1ps
`include "dma_transfer_hierarchy_defines.vh"

module dma_axil_regs
(
	// clock and reset
	input  wire                 aclk,
	input  wire                 aresetn,
	// axi4-lite write
	input  wire [7:0]           s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	// axi4-lite read
	input  wire [7:0]           s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output reg  [31:0]          s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready,
	// settings to engine
	output reg  [`CC_WIDTH-1:0] cfg_ctrl,
	output reg  [31:0]          cfg_src,
	output reg  [31:0]          cfg_dst,
	output reg  [31:0]          cfg_ublen,
	output reg  [31:0]          cfg_blen,
	output reg  [31:0]          cfg_step,
	output reg  [31:0]          cfg_soff,
	output reg  [31:0]          cfg_doff,
	output reg  [31:0]          cfg_next,
	output reg                  start,
	// engine state
	input  wire [31:0]          status
);

wire        wr_go;
wire        rd_go;
wire [31:0] wmask;
reg  [31:0] rd_val;
reg         rd_hit;
reg         wr_hit;

assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready  = wr_go;
assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
assign s_axi_arready = rd_go;
assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
	{8{s_axi_wstrb[0]}}};

always @*
begin
	wr_hit = 1'b1;
	case (s_axi_awaddr)
		`OFS_CTRL, `OFS_SRC, `OFS_DST, `OFS_UBLEN, `OFS_BLEN,
		`OFS_STEP, `OFS_SOFF, `OFS_DOFF, `OFS_NEXT: wr_hit = 1'b1;
		default: wr_hit = 1'b0;
	endcase
end

always @*
begin
	rd_hit = 1'b1;
	case (s_axi_araddr)
		`OFS_CTRL:   rd_val = {12'h000, cfg_ctrl};
		`OFS_SRC:    rd_val = cfg_src;
		`OFS_DST:    rd_val = cfg_dst;
		`OFS_UBLEN:  rd_val = cfg_ublen;
		`OFS_BLEN:   rd_val = cfg_blen;
		`OFS_STEP:   rd_val = cfg_step;
		`OFS_SOFF:   rd_val = cfg_soff;
		`OFS_DOFF:   rd_val = cfg_doff;
		`OFS_NEXT:   rd_val = cfg_next;
		`OFS_STATUS: rd_val = status;
		default:
		begin
			rd_val = `RST_WORD;
			rd_hit = 1'b0;
		end
	endcase
end

// ----------------------------------------
// write side
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		cfg_ctrl     <= `RST_CTRL;
		cfg_src      <= `RST_WORD;
		cfg_dst      <= `RST_WORD;
		cfg_ublen    <= `RST_WORD;
		cfg_blen     <= `RST_WORD;
		cfg_step     <= `RST_WORD;
		cfg_soff     <= `RST_WORD;
		cfg_doff     <= `RST_WORD;
		cfg_next     <= `RST_WORD;
		start        <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= 2'b00;
	end
	else
	begin
		start <= 1'b0;
		if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
			case (s_axi_awaddr)
				`OFS_CTRL:
				begin
					cfg_ctrl <= (cfg_ctrl & ~wmask[`CC_WIDTH-1:0])
						| (s_axi_wdata[`CC_WIDTH-1:0] & wmask[`CC_WIDTH-1:0]);
					start <= s_axi_wdata[`CC_START] & s_axi_wstrb[0];
				end
				`OFS_SRC:   cfg_src   <= (cfg_src & ~wmask) | (s_axi_wdata & wmask);
				`OFS_DST:   cfg_dst   <= (cfg_dst & ~wmask) | (s_axi_wdata & wmask);
				`OFS_UBLEN: cfg_ublen <= (cfg_ublen & ~wmask) | (s_axi_wdata & wmask);
				`OFS_BLEN:  cfg_blen  <= (cfg_blen & ~wmask) | (s_axi_wdata & wmask);
				`OFS_STEP:  cfg_step  <= (cfg_step & ~wmask) | (s_axi_wdata & wmask);
				`OFS_SOFF:  cfg_soff  <= (cfg_soff & ~wmask) | (s_axi_wdata & wmask);
				`OFS_DOFF:  cfg_doff  <= (cfg_doff & ~wmask) | (s_axi_wdata & wmask);
				`OFS_NEXT:  cfg_next  <= (cfg_next & ~wmask) | (s_axi_wdata & wmask);
				default:    cfg_next  <= cfg_next;
			endcase
		end
	end
end

// ----------------------------------------
// read side
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= `RST_WORD;
		s_axi_rresp  <= 2'b00;
	end
	else if (rd_go)
	begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata  <= rd_val;
		s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
	end
	else if (s_axi_rready)
		s_axi_rvalid <= 1'b0;
end

endmodule // dma_axil_regs

// ### dma_transfer_hierarchy.v
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dma_transfer_hierarchy_defines.vh"


module dma_transfer_hierarchy
(
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite register slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// peripheral request lines
	input  wire [63:0] req_lines,
	// memory master port
	output wire        mem_req,
	output wire        mem_we,
	output wire [31:0] mem_addr,
	output wire [31:0] mem_wdata,
	output wire [4:0]  mem_burst_len,
	input  wire        mem_ready,
	input  wire        mem_rvalid,
	input  wire [31:0] mem_rdata,
	// event pulses
	output reg         block_event,
	output reg         list_event
);

localparam [7:0] S_IDLE  = 8'h01;
localparam [7:0] S_BLOCK = 8'h02;
localparam [7:0] S_GROUP = 8'h04;
localparam [7:0] S_WAIT  = 8'h08;
localparam [7:0] S_RD    = 8'h10;
localparam [7:0] S_RDW   = 8'h20;
localparam [7:0] S_WR    = 8'h40;
localparam [7:0] S_DESC  = 8'h80;

wire [`CC_WIDTH-1:0] cfg_ctrl;
wire [31:0]          cfg_src;
wire [31:0]          cfg_dst;
wire [31:0]          cfg_ublen;
wire [31:0]          cfg_blen;
wire [31:0]          cfg_step;
wire [31:0]          cfg_soff;
wire [31:0]          cfg_doff;
wire [31:0]          cfg_next;
wire                 start;
wire                 req_sel;
wire [31:0]          status;

reg  [7:0]           state;
reg  [`CC_WIDTH-1:0] ctl;
reg  [31:0]          src;
reg  [31:0]          dst;
reg  [15:0]          ublen;
reg  [15:0]          blen;
reg  [31:0]          step;
reg  [31:0]          soff;
reg  [31:0]          doff;
reg  [31:0]          nxt;
reg  [31:0]          dptr;
reg  [5:0]           dmask;
reg  [2:0]           didx;
reg                  desc_rd;
reg  [15:0]          item_rem;
reg  [15:0]          mb_rem;
reg  [4:0]           grp;
reg  [4:0]           idx;
reg                  busy;
reg                  eol;
reg  [15:0]          blocks;
reg  [31:0]          buffer [0:`BUF_DEPTH-1];

wire                 sync_mode;
wire [4:0]           burst_cap;
wire [4:0]           chunk_cap;
wire [4:0]           unit_cap;
wire [4:0]           next_grp;
wire [31:0]          src_step;
wire [31:0]          dst_step;
wire                 take;
wire                 last_item;

// ----------------------------------------
// register slave and request selection
// ----------------------------------------
dma_axil_regs u_regs
(
	.aclk          (aclk),
	.aresetn       (aresetn),
	.s_axi_awaddr  (s_axi_awaddr),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wdata   (s_axi_wdata),
	.s_axi_wstrb   (s_axi_wstrb),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_araddr  (s_axi_araddr),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rresp   (s_axi_rresp),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.cfg_ctrl      (cfg_ctrl),
	.cfg_src       (cfg_src),
	.cfg_dst       (cfg_dst),
	.cfg_ublen     (cfg_ublen),
	.cfg_blen      (cfg_blen),
	.cfg_step      (cfg_step),
	.cfg_soff      (cfg_soff),
	.cfg_doff      (cfg_doff),
	.cfg_next      (cfg_next),
	.start         (start),
	.status        (status)
);

dma_request_select u_req
(
	.aclk                  (aclk),
	.aresetn               (aresetn),
	.req_lines             (req_lines),
	.peripheral_request_id (ctl[`CC_PERIPHERAL_REQUEST_ID_HI:`CC_PERIPHERAL_REQUEST_ID_LO]),
	.req_sel               (req_sel)
);

// ----------------------------------------
// group sizing
// ----------------------------------------
function [4:0] cap_of;
	input [2:0] code;
	begin
		if (code > 3'h4)
			cap_of = `MAX_GROUP;
		else
			cap_of = 5'h01 << code;
	end
endfunction

assign sync_mode = ctl[`CC_SYNC];
assign burst_cap = cap_of(ctl[`CC_BURST_HI:`CC_BURST_LO]);
assign chunk_cap = cap_of(ctl[`CC_CHUNK_HI:`CC_CHUNK_LO]);
assign unit_cap  = sync_mode ? chunk_cap : burst_cap;
assign next_grp  = (item_rem < {11'h000, unit_cap}) ? item_rem[4:0] : unit_cap;
assign src_step  = ctl[`CC_SFIX] ? 32'h0000_0000 : {{16{step[15]}}, step[15:0]};
assign dst_step  = ctl[`CC_DFIX] ? 32'h0000_0000 : {{16{step[31]}}, step[31:16]};
assign last_item = (idx == grp - 5'h01);

// ----------------------------------------
// memory port
// ----------------------------------------
assign mem_req       = (state == S_RD) | (state == S_WR) | ((state == S_DESC) & ~desc_rd);
assign mem_we        = (state == S_WR);
assign mem_addr      = (state == S_WR) ? dst : ((state == S_DESC) ? dptr : src);
assign mem_wdata     = buffer[idx[3:0]];
assign mem_burst_len = (state == S_DESC) ? 5'h01 : grp;
assign take          = mem_req & mem_ready;
assign status        = {blocks, 14'h0000, eol, busy};

// ----------------------------------------
// transfer sequencer
// ----------------------------------------
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		state       <= S_IDLE;
		ctl         <= `RST_CTRL;
		src         <= `RST_WORD;
		dst         <= `RST_WORD;
		ublen       <= 16'h0000;
		blen        <= 16'h0000;
		step        <= `RST_WORD;
		soff        <= `RST_WORD;
		doff        <= `RST_WORD;
		nxt         <= `RST_WORD;
		dptr        <= `RST_WORD;
		dmask       <= 6'h00;
		didx        <= 3'h0;
		desc_rd     <= 1'b0;
		item_rem    <= 16'h0000;
		mb_rem      <= 16'h0000;
		grp         <= 5'h00;
		idx         <= 5'h00;
		busy        <= 1'b0;
		eol         <= 1'b0;
		blocks      <= 16'h0000;
		block_event <= 1'b0;
		list_event  <= 1'b0;
	end
	else
	begin
		block_event <= 1'b0;
		list_event  <= 1'b0;
		case (state)
			S_IDLE:
			begin
				if (start)
				begin
					ctl    <= cfg_ctrl;
					src    <= cfg_src;
					dst    <= cfg_dst;
					ublen  <= cfg_ublen[15:0];
					blen   <= cfg_blen[15:0];
					step   <= cfg_step;
					soff   <= cfg_soff;
					doff   <= cfg_doff;
					nxt    <= cfg_next;
					busy   <= 1'b1;
					eol    <= 1'b0;
					blocks <= 16'h0000;
					state  <= S_BLOCK;
				end
			end
			S_BLOCK:
			begin
				mb_rem   <= blen;
				item_rem <= ublen;
				state    <= S_GROUP;
			end
			S_GROUP:
			begin
				idx <= 5'h00;
				grp <= next_grp;
				if (item_rem != 16'h0000)
					state <= sync_mode ? S_WAIT : S_RD;
				else if (mb_rem > 16'h0001)
				begin
					// microblock boundary
					mb_rem   <= mb_rem - 16'h0001;
					item_rem <= ublen;
					if (ctl[`CC_SOFF_EN])
						src <= src + soff;
					if (ctl[`CC_DOFF_EN])
						dst <= dst + doff;
				end
				else
				begin
					// block boundary
					blocks      <= blocks + 16'h0001;
					block_event <= ctl[`CC_IRQ_BLK];
					if (nxt == `RST_WORD)
					begin
						busy       <= 1'b0;
						eol        <= 1'b1;
						list_event <= ctl[`CC_IRQ_EOL];
						state      <= S_IDLE;
					end
					else
					begin
						dptr    <= nxt;
						didx    <= 3'h0;
						desc_rd <= 1'b0;
						state   <= S_DESC;
					end
				end
			end
			S_WAIT:
			begin
				if (req_sel)
					state <= S_RD;
			end
			S_RD:
			begin
				if (take)
					state <= S_RDW;
			end
			S_RDW:
			begin
				if (mem_rvalid)
				begin
					buffer[idx[3:0]] <= mem_rdata;
					src              <= src + src_step;
					if (last_item)
					begin
						idx   <= 5'h00;
						state <= S_WR;
					end
					else
					begin
						idx   <= idx + 5'h01;
						state <= S_RD;
					end
				end
			end
			S_WR:
			begin
				if (take)
				begin
					dst <= dst + dst_step;
					idx <= idx + 5'h01;
					if (last_item)
					begin
						item_rem <= item_rem - {11'h000, grp};
						state    <= S_GROUP;
					end
				end
			end
			S_DESC:
			begin
				if (take)
					desc_rd <= 1'b1;
				if (desc_rd && mem_rvalid)
				begin
					desc_rd <= 1'b0;
					dptr    <= dptr + 32'h0000_0004;
					didx    <= didx + 3'h1;
					case (didx)
						3'h0: nxt   <= mem_rdata;
						3'h1: dmask <= mem_rdata[5:0];
						3'h2: if (dmask[`DM_SRC]) src <= mem_rdata;
						3'h3: if (dmask[`DM_DST]) dst <= mem_rdata;
						3'h4: if (dmask[`DM_UBLEN]) ublen <= mem_rdata[15:0];
						3'h5: if (dmask[`DM_BLEN]) blen <= mem_rdata[15:0];
						3'h6: if (dmask[`DM_STEP]) step <= mem_rdata;
						default: if (dmask[`DM_CTRL]) ctl <= mem_rdata[`CC_WIDTH-1:0];
					endcase
					if (didx == `DESC_WORDS)
						state <= S_BLOCK;
				end
			end
			default:
				state <= S_IDLE;
		endcase
	end
end

endmodule // dma_transfer_hierarchy

// ### dma_checker_properties.sv
`timescale 1ns/1ps
module dma_checker
(
	// clock and reset
	input logic        aclk,
	input logic        aresetn,
	// register bus
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	// memory port and events
	input logic        mem_req,
	input logic        mem_we,
	input logic [31:0] mem_addr,
	input logic [4:0]  mem_burst_len,
	input logic        mem_ready,
	input logic        block_event,
	input logic        list_event
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write answer missing");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_gate: assert property (s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
		else $error("write taken while answer pending");
	a_mem_req_hold: assert property (mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request changed before take");
	a_burst_cap: assert property (mem_req |-> mem_burst_len inside {[1:16]})
		else $error("group size out of range");
	a_block_pulse: assert property (block_event |=> !block_event)
		else $error("block event longer than a cycle");
	a_list_pulse: assert property (list_event |=> !list_event)
		else $error("list event longer than a cycle");
endmodule // dma_checker

// ### mem_model.sv
`timescale 1ns/1ps
module mem_model
(
	// clock and pace
	input  logic        aclk,
	input  logic        slow,
	// memory port
	input  logic        mem_req,
	input  logic        mem_we,
	input  logic [31:0] mem_addr,
	input  logic [31:0] mem_wdata,
	output logic        mem_ready,
	output logic        mem_rvalid,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:511];
	logic [8:0]  rd_idx;
	logic        pend;
	logic [1:0]  wait_cnt;
	initial
	begin
		for (int i = 0; i < 512; i++)
			mem[i] = 32'h0000_0000;
		{mem_ready, mem_rvalid, pend, wait_cnt, rd_idx} = '0;
		mem_rdata = 32'hA5A5_5A5A;
	end
	always @(posedge aclk)
	begin
		mem_ready <= slow ? ~mem_ready : 1'b1;
		mem_rvalid <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && mem_ready && mem_we)
			mem[mem_addr[10:2]] <= mem_wdata;
		else if (mem_req && mem_ready)
		begin
			pend <= 1'b1;
			rd_idx <= mem_addr[10:2];
			wait_cnt <= slow ? 2'h2 : 2'h0;
		end
		else if (pend && wait_cnt == 2'h0)
		begin
			mem_rvalid <= 1'b1;
			mem_rdata <= mem[rd_idx];
			pend <= 1'b0;
		end
		else if (pend)
			wait_cnt <= wait_cnt - 2'h1;
	end
endmodule // mem_model

// ### testbench.sv
`timescale 1ns/1ps
`include "dma_transfer_hierarchy_defines.vh"
`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, mem_req, mem_we, mem_ready, mem_rvalid, block_event, list_event;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [4:0]  mem_burst_len;
	logic [63:0] req_lines = 64'h0;
	int          failures = 0, n_compared = 0, cycles = 0, n_blk = 0, n_eol = 0, n_take = 0;
	always #5 aclk = ~aclk;
	dma_transfer_hierarchy dma_transfer_hierarchy_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .req_lines(req_lines),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_burst_len(mem_burst_len), .mem_ready(mem_ready), .mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata), .block_event(block_event), .list_event(list_event));
	mem_model mem_model_i (.aclk(aclk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
	// ----------------------------------------
	// closing, watchdog and event counts
	// ----------------------------------------
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		n_blk <= n_blk + int'(block_event === 1'b1);
		n_eol <= n_eol + int'(list_event === 1'b1);
		n_take <= n_take + int'(mem_req === 1'b1 && mem_ready === 1'b1);
		if (cycles == 30000)
		begin
			failures++;
			complete_run;
		end
	end
	// ----------------------------------------
	// register bus tasks
	// ----------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		#1;
		while (s_axi_awready !== 1'b1) begin @(posedge aclk); #1; end
		@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		#1;
		while (s_axi_bvalid !== 1'b1) begin @(posedge aclk); #1; end
		r = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		`CHECK("bresp", er, r)
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		#1;
		while (s_axi_arready !== 1'b1) begin @(posedge aclk); #1; end
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		#1;
		while (s_axi_rvalid !== 1'b1) begin @(posedge aclk); #1; end
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic setup(input logic [31:0] src, dst, ublen, blen, step, nxt, ctrl);
		axi_write(`OFS_SRC, src, 2'b00);
		axi_write(`OFS_DST, dst, 2'b00);
		axi_write(`OFS_UBLEN, ublen, 2'b00);
		axi_write(`OFS_BLEN, blen, 2'b00);
		axi_write(`OFS_STEP, step, 2'b00);
		axi_write(`OFS_NEXT, nxt, 2'b00);
		axi_write(`OFS_CTRL, ctrl, 2'b00);
	endtask
	task automatic wait_idle;
		logic [31:0] d;
		logic [1:0]  r;
		do axi_read(`OFS_STATUS, d, r); while (d[0] !== 1'b0);
		`CHECK("end of list flag", 1'b1, d[1])
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(`OFS_STATUS, d, r);
		`CHECK("status reset", 32'h0000_0000, d)
		axi_read(8'h80, d, r);
		`CHECK("unmapped rresp", 2'b10, r)
		axi_write(8'h80, 32'h1111_1111, 2'b10);
		axi_write(`OFS_STATUS, 32'hFFFF_FFFF, 2'b10);
		axi_write(`OFS_SOFF, 32'h1234_5678, 2'b00);
		axi_read(`OFS_SOFF, d, r);
		`CHECK("soff readback", 32'h1234_5678, d)
		axi_write(`OFS_SOFF, 32'h0, 2'b00);
		$display("regs done");
	endtask
	task automatic t_copy;
		int b0, e0;
		b0 = n_blk;
		e0 = n_eol;
		for (int i = 0; i < 8; i++)
			mem_model_i.mem[9'h40 + i] = 32'hA000_0000 + i;
		axi_write(`OFS_SOFF, 32'h8, 2'b00);
		setup(32'h100, 32'h200, 32'd3, 32'd2, 32'h0004_0004, 32'h0, 32'h000D_0101);
		wait_idle;
		for (int i = 0; i < 6; i++)
			`CHECK("copied item", 32'hA000_0000 + i + (i > 2 ? 2 : 0),
				mem_model_i.mem[9'h80 + i])
		`CHECK("item past end", 32'h0, mem_model_i.mem[9'h86])
		`CHECK("block events", b0 + 1, n_blk)
		`CHECK("list events", e0 + 1, n_eol)
		$display("copy done");
	endtask
	task automatic t_fixed;
		int b0;
		b0 = n_blk;
		mem_model_i.mem[9'h60] = 32'hC0DE_0001;
		setup(32'h180, 32'h280, 32'd4, 32'd1, 32'h0004_0004, 32'h0, 32'h0000_4001);
		wait_idle;
		for (int i = 0; i < 4; i++)
			`CHECK("fixed source item", 32'hC0DE_0001, mem_model_i.mem[9'hA0 + i])
		`CHECK("events masked", b0, n_blk)
		$display("fixed done");
	endtask
	task automatic t_paced;
		int t0;
		for (int i = 0; i < 4; i++)
			mem_model_i.mem[9'hC0 + i] = 32'hB000_0000 + i;
		setup(32'h300, 32'h380, 32'd4, 32'd1, 32'h0004_0004, 32'h0,
			32'h0008_0803 | (32'(`REQ_AUDIO_A_RX_LEFT) << 2));
		t0 = n_take;
		req_lines[`REQ_AUDIO_B_RX_RIGHT] <= 1'b1;
		repeat (40) @(posedge aclk);
		`CHECK("takes without request", t0, n_take)
		req_lines <= 64'h1 << `REQ_AUDIO_A_RX_LEFT;
		wait_idle;
		req_lines[`REQ_AUDIO_A_RX_LEFT] <= 1'b0;
		for (int i = 0; i < 4; i++)
			`CHECK("paced item", 32'hB000_0000 + i, mem_model_i.mem[9'hE0 + i])
		$display("paced done");
	endtask
	task automatic t_chain;
		int b0, e0;
		logic [31:0] dw [0:7] = '{32'h0, 32'h7, 32'h700, 32'h780, 32'd2, 32'd5, 32'h0, 32'h0};
		b0 = n_blk;
		e0 = n_eol;
		slow <= 1'b1;
		for (int i = 0; i < 8; i++)
			mem_model_i.mem[9'h180 + i] = dw[i];
		mem_model_i.mem[9'h1C0] = 32'hD000_0000;
		mem_model_i.mem[9'h1C1] = 32'hD000_0001;
		mem_model_i.mem[9'h1C2] = 32'hD000_0002;
		setup(32'h100, 32'h7C0, 32'd1, 32'd1, 32'h0004_0004, 32'h600, 32'h000C_0001);
		wait_idle;
		`CHECK("first block item", 32'hA000_0000, mem_model_i.mem[9'h1F0])
		`CHECK("second block item 0", 32'hD000_0000, mem_model_i.mem[9'h1E0])
		`CHECK("second block item 1", 32'hD000_0001, mem_model_i.mem[9'h1E1])
		`CHECK("unmarked length kept", 32'h0, mem_model_i.mem[9'h1E2])
		`CHECK("chain block events", b0 + 2, n_blk)
		`CHECK("chain list events", e0 + 1, n_eol)
		slow <= 1'b0;
		$display("chain done");
	endtask
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_copy;
		t_fixed;
		t_paced;
		t_chain;
		complete_run;
	end
endmodule // testbench
bind dma_transfer_hierarchy dma_checker dma_checker_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_req(mem_req),
	.mem_we(mem_we), .mem_addr(mem_addr), .mem_burst_len(mem_burst_len),
	.mem_ready(mem_ready), .block_event(block_event), .list_event(list_event));
